// ==== fssr_consts.vh ====
// Constants for the four stage shift register ring: map, fields, resets.
`ifndef FSSR_CONSTS_VH
`define FSSR_CONSTS_VH

// ----------------------------------------------------------------------
// Register port geometry
// ----------------------------------------------------------------------
`define FSSR_ADDR_W 4
`define FSSR_DATA_W 8

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FSSR_OFS_CTRL 4'h0
`define FSSR_OFS_FLASH_LO 4'h1
`define FSSR_OFS_FLASH_HI 4'h2
`define FSSR_OFS_STATUS 4'h3
`define FSSR_OFS_LOG 4'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FSSR_CTRL_RUN_BIT 0
`define FSSR_CTRL_SOFT_CLR_BIT 1
`define FSSR_CTRL_OVF_CLR_BIT 2
`define FSSR_ST_LATCH_BIT 4
`define FSSR_ST_EMPTY_BIT 5
`define FSSR_ST_FULL_BIT 6
`define FSSR_ST_OVF_BIT 7
`define FSSR_LOG_VALID_BIT 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FSSR_CTRL_RST 8'h00
`define FSSR_FLASH_RST 16'h01f4

// ----------------------------------------------------------------------
// Timing and buffering
// ----------------------------------------------------------------------
`define FSSR_CLK_PERIOD_NS 40
`define FSSR_TICK_NS 1000000
// One millisecond of 40 ns cycles, sized to the prescaler.
`define FSSR_TICK_CYCLES 24'd25000
`define FSSR_LOG_W 4
`define FSSR_LOG_DEPTH 16
`define FSSR_LOG_AW 4

`endif

// ==== fssr_fifo.v ====
// Snapshot FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module fssr_fifo #(
  parameter W = 4,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] LAST_W = DEPTH - 1;
  localparam [AW:0] DEPTH_C = DEPTH_W[AW:0];
  localparam [AW-1:0] LAST_C = LAST_W[AW-1:0];

  assign in_ready = (cnt_q != DEPTH_C);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_q];

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_C) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_C) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // fssr_fifo

// ==== fssr_flasher.v ====
// Free-running flasher timer, toggling every half period of ticks.
`timescale 1ns/1ps
module fssr_flasher #(
  parameter [23:0] TICK_CYCLES = 24'd25000
) (
  input wire mclk,
  input wire rstn,
  input wire [15:0] half_period,
  output reg flash_q
);
  localparam [23:0] TICK_LAST = TICK_CYCLES - 24'h1;
  reg [23:0] presc_q;
  reg [15:0] ticks_q;
  wire tick;
  wire [15:0] limit;

  assign tick = (presc_q >= TICK_LAST);
  // A zero half period would stall the light; it is treated as one tick.
  assign limit = (half_period == 16'h0000) ? 16'h0001 : half_period;

  always @(posedge mclk) begin
    if (!rstn) begin
      presc_q <= 24'h000000;
      ticks_q <= 16'h0000;
      flash_q <= 1'b0;
    end else begin
      presc_q <= tick ? 24'h000000 : presc_q + 24'h000001;
      if (tick) begin
        if (ticks_q + 16'h0001 >= limit) begin
          ticks_q <= 16'h0000;
          flash_q <= ~flash_q;
        end else begin
          ticks_q <= ticks_q + 16'h0001;
        end
      end
    end
  end
endmodule // fssr_flasher

// ==== fssr_machine.sv ====
// Machine side: a sensor giving the part value and a shift pushbutton.
`timescale 1ns/1ps
module fssr_machine (
  input wire logic mclk,
  input wire logic press,
  input wire logic val,
  output logic shift_request_in,
  output logic shift_value_in
);
  logic [3:0] cnt_q = 4'h0;
  logic req_q = 1'b0;
  logic val_q = 1'b0;
  assign shift_request_in = req_q;
  assign shift_value_in = val_q;
  // The button stays pressed four cycles, released four; the sensor
  // flips its line after the press so a late sample shows up wrong.
  always @(posedge mclk) begin
    if (press) begin
      cnt_q <= 4'h8;
      req_q <= 1'b1;
      val_q <= val;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h5) req_q <= 1'b0;
      if (cnt_q == 4'h1) val_q <= ~val_q;
    end
  end
endmodule // fssr_machine

// ==== fssr_monitor.sv ====
// Concurrent checks on the ports of the shift register ring.
`timescale 1ns/1ps
`include "fssr_consts.vh"
module fssr_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic shift_request_in,
  input wire logic shift_value_in,
  input wire logic clear_all_in,
  input wire logic [`FSSR_ADDR_W-1:0] reg_addr,
  input wire logic [`FSSR_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`FSSR_DATA_W-1:0] reg_rdata_q,
  input wire logic store_pos_one,
  input wire logic store_pos_two,
  input wire logic store_pos_three,
  input wire logic store_pos_four,
  input wire logic one_cycle_shift_strobe,
  input wire logic light_out_one,
  input wire logic light_out_two,
  input wire logic light_out_three,
  input wire logic light_out_four
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic run_q;
  logic [4:0] busy_q;
  wire [3:0] pos = {store_pos_four, store_pos_three, store_pos_two,
    store_pos_one};
  wire [3:0] lit = {light_out_four, light_out_three, light_out_two,
    light_out_one};
  // Clear reaches the ring through sync flops and run mode through ctrl_q, so checks on
  // plain shifting wait until both have been quiet for a while.
  wire quiet = !run_q && busy_q == 5'h00 && !clear_all_in;
  wire stb = one_cycle_shift_strobe;
  wire soft_clr = reg_wr && reg_addr == `FSSR_OFS_CTRL &&
    reg_wdata[`FSSR_CTRL_SOFT_CLR_BIT];
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_q <= 1'b0;
      busy_q <= 5'h00;
    end else begin
      busy_q <= {busy_q[3:0], clear_all_in | run_q | soft_clr};
      if (reg_wr && reg_addr == `FSSR_OFS_CTRL) begin
        run_q <= reg_wdata[`FSSR_CTRL_RUN_BIT];
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_strobe_one_cycle: assert property (stb |=> !stb)
    else $error("strobe longer than one cycle");
  a_strobe_from_edge: assert property (stb && quiet |->
    $past(shift_request_in, 3) && !$past(shift_request_in, 4))
    else $error("strobe without a rising request");
  a_no_retrigger: assert property ((shift_request_in && quiet)[*2]
    |-> ##3 !stb) else $error("strobe while request stays high");
  a_true_shift: assert property (stb && quiet |=>
    pos == {$past(pos[2:0]), $past(shift_value_in, 3)})
    else $error("positions did not shift by one");
  a_hold_between: assert property (!stb && quiet |=> $stable(pos))
    else $error("positions moved without strobe");
  a_clear_zeroes: assert property (clear_all_in[*4] |=>
    pos == 4'h0) else $error("clear left a position set");
  a_lights_dark: assert property (!run_q[*3] |-> lit == 4'h0)
    else $error("lights on outside run mode");
  a_ring_rotates: assert property (run_q && stb && lit != 4'h0 |=>
    lit == {$past(lit[2:0]), $past(lit[3])})
    else $error("lit output did not rotate");
  a_read_idle: assert property (!$past(reg_rd) |->
    reg_rdata_q == 8'h00) else $error("read data outside read answer");
  a_status_pos: assert property (reg_rd &&
    reg_addr == `FSSR_OFS_STATUS |=> reg_rdata_q[3:0] == $past(pos))
    else $error("status positions differ");
  c_shift: cover property (stb && quiet);
  c_clear: cover property (clear_all_in[*4] ##1 pos == 4'h0);
  c_ring: cover property (run_q && lit == 4'h8 ##[1:20] lit == 4'h1);
endmodule // fssr_monitor

bind fssr_top fssr_monitor mon (.mclk(mclk), .rstn(rstn),
  .shift_request_in(shift_request_in), .shift_value_in(shift_value_in),
  .clear_all_in(clear_all_in), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .store_pos_one(store_pos_one),
  .store_pos_two(store_pos_two), .store_pos_three(store_pos_three),
  .store_pos_four(store_pos_four),
  .one_cycle_shift_strobe(one_cycle_shift_strobe),
  .light_out_one(light_out_one), .light_out_two(light_out_two),
  .light_out_three(light_out_three), .light_out_four(light_out_four));

// ==== fssr_top.v ====
// Four stage shift register ring with running-light mode and register port.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "fssr_consts.vh"

module fssr_top #(
  parameter [23:0] TICK_CYCLES = `FSSR_TICK_CYCLES
) (
  input wire mclk,
  input wire rstn,
  input wire shift_request_in,
  input wire shift_value_in,
  input wire clear_all_in,
  input wire [`FSSR_ADDR_W-1:0] reg_addr,
  input wire [`FSSR_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`FSSR_DATA_W-1:0] reg_rdata_q,
  output reg store_pos_one,
  output reg store_pos_two,
  output reg store_pos_three,
  output reg store_pos_four,
  output reg one_cycle_shift_strobe,
  output reg light_out_one,
  output reg light_out_two,
  output reg light_out_three,
  output reg light_out_four,
  output reg log_ready_q
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Address compare shared by the write decodes and the log pop.
  function hit;
    input [`FSSR_ADDR_W-1:0] a;
    input [`FSSR_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // The pins come from switches and sensors with no relation to mclk, so
  // each passes two flops before the ladder logic sees it.
  reg req_meta_q;
  reg req_sync_q;
  reg val_meta_q;
  reg val_sync_q;
  reg clr_meta_q;
  reg clr_sync_q;

  always @(posedge mclk) begin
    if (!rstn) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      val_meta_q <= 1'b0;
      val_sync_q <= 1'b0;
      clr_meta_q <= 1'b0;
      clr_sync_q <= 1'b0;
    end else begin
      req_meta_q <= shift_request_in;
      req_sync_q <= req_meta_q;
      val_meta_q <= shift_value_in;
      val_sync_q <= val_meta_q;
      clr_meta_q <= clear_all_in;
      clr_sync_q <= clr_meta_q;
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  reg [`FSSR_DATA_W-1:0] ctrl_q;
  reg [15:0] flash_half_q;
  reg soft_clr_q;
  reg ovf_q;
  wire run_mode;
  wire wr_ctrl;
  wire rd_log;

  assign run_mode = ctrl_q[`FSSR_CTRL_RUN_BIT];
  assign wr_ctrl = reg_wr & hit(reg_addr, `FSSR_OFS_CTRL);
  assign rd_log = reg_rd & hit(reg_addr, `FSSR_OFS_LOG);

  // Only the run bit is stored; the two clear bits are one-cycle commands
  // and always read back as zero.

  always @(posedge mclk) begin
    if (!rstn) begin
      ctrl_q <= `FSSR_CTRL_RST;
      flash_half_q <= `FSSR_FLASH_RST;
      soft_clr_q <= 1'b0;
    end else begin
      // A software clear lasts one cycle and acts like the clear pin.
      soft_clr_q <= wr_ctrl & reg_wdata[`FSSR_CTRL_SOFT_CLR_BIT];
      if (wr_ctrl) begin
        ctrl_q <= {{(`FSSR_DATA_W-1){1'b0}}, reg_wdata[`FSSR_CTRL_RUN_BIT]};
      end
      if (reg_wr && hit(reg_addr, `FSSR_OFS_FLASH_LO)) begin
        flash_half_q[7:0] <= reg_wdata;
      end
      if (reg_wr && hit(reg_addr, `FSSR_OFS_FLASH_HI)) begin
        flash_half_q[15:8] <= reg_wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Flasher timer
  // --------------------------------------------------------------------
  // The flasher runs on mclk itself, so it needs no synchroniser; it runs
  // in both modes and only the ring mode listens to it.
  wire flasher_timer;

  fssr_flasher #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_flasher (
    .mclk(mclk),
    .rstn(rstn),
    .half_period(flash_half_q),
    .flash_q(flasher_timer)
  );

  // --------------------------------------------------------------------
  // Edge to strobe
  // --------------------------------------------------------------------
  reg edge_memory_flag;
  reg first_value_latch;
  wire shift_req;
  wire strobe_d;
  wire clear_all;
  wire inject_wait;

  assign shift_req = run_mode ? flasher_timer : req_sync_q;
  // Pin clear and software clear act alike and share one priority.
  assign clear_all = clr_sync_q | soft_clr_q;
  // In the ring the strobe waits until the injected one is latched; a
  // flasher edge met at mode entry would otherwise light two outputs.
  assign inject_wait = run_mode & ~first_value_latch;
  // The strobe coil is computed from the flag's old contact value, so it
  // can only be high in the one cycle before the flag catches up.
  assign strobe_d = shift_req & ~edge_memory_flag &
                    ~inject_wait;

  always @(posedge mclk) begin
    if (!rstn) begin
      edge_memory_flag <= 1'b0;
      one_cycle_shift_strobe <= 1'b0;
    end else begin
      edge_memory_flag <= shift_req;
      // Registered so storage sees it one cycle later, for one cycle.
      one_cycle_shift_strobe <= strobe_d;
    end
  end

  // --------------------------------------------------------------------
  // Storage ladder
  // --------------------------------------------------------------------
  // Rungs are written top to bottom in one process; the last write to a
  // coil wins, which is what gives clear its priority.
  reg pos1_d;
  reg pos2_d;
  reg pos3_d;
  reg pos4_d;
  reg latch_d;
  wire shift_val;

  // The ring recirculates the last position into the first.
  assign shift_val = run_mode ? store_pos_four : val_sync_q;

  always @* begin
    pos1_d = store_pos_one;
    pos2_d = store_pos_two;
    pos3_d = store_pos_three;
    pos4_d = store_pos_four;
    // Leaving the ring mode drops the latch, so the next entry injects a
    // fresh one; the positions themselves keep their values.
    latch_d = run_mode & first_value_latch;
    // The latch takes output one's contact as of this cycle.
    if (run_mode && store_pos_one) begin
      latch_d = 1'b1;
    end
    if (one_cycle_shift_strobe) begin
      pos4_d = store_pos_three;
      pos3_d = store_pos_two;
      pos2_d = store_pos_one;
      pos1_d = shift_val;
    end
    if (run_mode && !first_value_latch) begin
      pos1_d = 1'b1;
    end
    if (clear_all) begin
      pos1_d = 1'b0;
      pos2_d = 1'b0;
      pos3_d = 1'b0;
      pos4_d = 1'b0;
      latch_d = 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      store_pos_one <= 1'b0;
      store_pos_two <= 1'b0;
      store_pos_three <= 1'b0;
      store_pos_four <= 1'b0;
      first_value_latch <= 1'b0;
      light_out_one <= 1'b0;
      light_out_two <= 1'b0;
      light_out_three <= 1'b0;
      light_out_four <= 1'b0;
    end else begin
      store_pos_one <= pos1_d;
      store_pos_two <= pos2_d;
      store_pos_three <= pos3_d;
      store_pos_four <= pos4_d;
      first_value_latch <= latch_d;
      // Lights copy the positions only in the ring mode, on the same edge.
      light_out_one <= run_mode & pos1_d;
      light_out_two <= run_mode & pos2_d;
      light_out_three <= run_mode & pos3_d;
      light_out_four <= run_mode & pos4_d;
    end
  end

  // --------------------------------------------------------------------
  // Snapshot log
  // --------------------------------------------------------------------
  // After each strobe without a clear the new content of the four positions is queued so
  // software can follow the conveyor without polling every step. When the
  // queue is full the snapshot is dropped and the overflow flag is raised;
  // stalling the ladder instead would break the one-cycle strobe timing.
  reg push_q;
  wire log_in_ready;
  wire log_out_valid;
  wire [`FSSR_LOG_W-1:0] log_out_data;
  wire [`FSSR_LOG_W-1:0] snap;
  wire ovf_clr;

  assign snap = {store_pos_four, store_pos_three, store_pos_two,
                 store_pos_one};
  assign ovf_clr = wr_ctrl & reg_wdata[`FSSR_CTRL_OVF_CLR_BIT];

  fssr_fifo #(
    .W(`FSSR_LOG_W),
    .DEPTH(`FSSR_LOG_DEPTH),
    .AW(`FSSR_LOG_AW)
  ) u_log (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(push_q),
    .in_ready(log_in_ready),
    .in_data(snap),
    .out_valid(log_out_valid),
    .out_ready(rd_log),
    .out_data(log_out_data)
  );

  always @(posedge mclk) begin
    if (!rstn) begin
      push_q <= 1'b0;
      ovf_q <= 1'b0;
      log_ready_q <= 1'b0;
    end else begin
      // Pushed one cycle after the strobe, when the shifted values stand.
      push_q <= one_cycle_shift_strobe & ~clear_all;
      log_ready_q <= log_in_ready;
      // A drop in the same cycle as the clear keeps the flag set.
      if (push_q && !log_in_ready) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  // Unmapped addresses read as zero; writes to them are dropped.
  reg [`FSSR_DATA_W-1:0] rd_mux;

  always @* begin
    rd_mux = {`FSSR_DATA_W{1'b0}};
    case (reg_addr)
      `FSSR_OFS_CTRL: begin
        rd_mux = ctrl_q;
      end
      `FSSR_OFS_FLASH_LO: begin
        rd_mux = flash_half_q[7:0];
      end
      `FSSR_OFS_FLASH_HI: begin
        rd_mux = flash_half_q[15:8];
      end
      `FSSR_OFS_STATUS: begin
        rd_mux[`FSSR_LOG_W-1:0] = snap;
        rd_mux[`FSSR_ST_LATCH_BIT] = first_value_latch;
        rd_mux[`FSSR_ST_EMPTY_BIT] = ~log_out_valid;
        rd_mux[`FSSR_ST_FULL_BIT] = ~log_in_ready;
        rd_mux[`FSSR_ST_OVF_BIT] = ovf_q;
      end
      `FSSR_OFS_LOG: begin
        rd_mux[`FSSR_LOG_W-1:0] = log_out_valid ? log_out_data :
                                  {`FSSR_LOG_W{1'b0}};
        rd_mux[`FSSR_LOG_VALID_BIT] = log_out_valid;
      end
      default: begin
        rd_mux = {`FSSR_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata_q <= {`FSSR_DATA_W{1'b0}};
    end else begin
      // Read data stand only in the cycle after the strobe.
      // A stale word can thus never pass for a fresh answer.
      reg_rdata_q <= reg_rd ? rd_mux : {`FSSR_DATA_W{1'b0}};
    end
  end

endmodule // fssr_top

// ==== test_four_stage_shift_register_ring.sv ====
// Self-checking bench for the four stage shift register ring.
`timescale 1ns/1ps
`include "fssr_consts.vh"
module test_four_stage_shift_register_ring;
  logic mclk, rstn, clr, press, val, req, sval, wr, rd, stb, lrdy;
  logic p1, p2, p3, p4, l1, l2, l3, l4;
  logic [3:0] addr, mdl, lexp, lprev;
  logic [7:0] wdata, rdata, rv, rnd;
  logic [3:0] snaps[$];
  logic ovf;
  int n_mismatch = 0;
  int checks_done = 0;
  int nchg = 0;
  fssr_machine mach (.mclk(mclk), .press(press), .val(val),
    .shift_request_in(req), .shift_value_in(sval));
  fssr_top #(.TICK_CYCLES(24'd4)) uut (.mclk(mclk), .rstn(rstn),
    .shift_request_in(req), .shift_value_in(sval), .clear_all_in(clr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_q(rdata), .store_pos_one(p1), .store_pos_two(p2),
    .store_pos_three(p3), .store_pos_four(p4),
    .one_cycle_shift_strobe(stb), .light_out_one(l1),
    .light_out_two(l2), .light_out_three(l3), .light_out_four(l4),
    .log_ready_q(lrdy));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge mclk);
  endtask
  task automatic shift_in(input logic v);
    int nstb = 0;
    press <= 1'b1;
    val <= v;
    @(posedge mclk);
    press <= 1'b0;
    repeat (11) begin
      @(posedge mclk);
      nstb += stb;
    end
    mdl = clr ? 4'h0 : {mdl[2:0], v};
    if (!clr && snaps.size() < 16) snaps.push_back(mdl);
    else if (!clr) ovf = 1'b1;
    check({4'h0, p4, p3, p2, p1}, {4'h0, mdl});
    check({7'h0, nstb == 1}, 8'h01);
  endtask
  task automatic status_and_drain;
    rd_reg(`FSSR_OFS_STATUS, rv);
    check(rv, {ovf, snaps.size() == 16, snaps.size() == 0, 1'b0, mdl});
    check({7'h0, lrdy}, {7'h0, snaps.size() != 16});
    while (snaps.size() > 0) begin
      rd_reg(`FSSR_OFS_LOG, rv);
      check(rv, {4'h8, snaps.pop_front()});
    end
    rd_reg(`FSSR_OFS_LOG, rv);
    check(rv, 8'h00);
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, clr, press, val, wr, rd, ovf} = 7'h00;
    addr = 4'h0;
    wdata = 8'h00;
    mdl = 4'h0;
    void'($urandom(32'h3668));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd_reg(`FSSR_OFS_CTRL, rv);
    check(rv, `FSSR_CTRL_RST);
    rd_reg(`FSSR_OFS_FLASH_LO, rv);
    check(rv, 8'hf4);
    rd_reg(`FSSR_OFS_FLASH_HI, rv);
    check(rv, 8'h01);
    rd_reg(4'hf, rv);
    check(rv, 8'h00);
    for (int i = 0; i < 5; i++) shift_in(i == 0 || i == 3);
    status_and_drain();
    for (int i = 0; i < 19; i++) shift_in(1'($urandom));
    status_and_drain();
    wr_reg(`FSSR_OFS_CTRL, 8'h06);
    ovf = 1'b0;
    mdl = 4'h0;
    @(posedge mclk);
    check({4'h0, p4, p3, p2, p1}, 8'h00);
    clr <= 1'b1;
    repeat (3) @(posedge mclk);
    shift_in(1'b1);
    status_and_drain();
    clr <= 1'b0;
    rnd = 8'($urandom);
    wr_reg(`FSSR_OFS_FLASH_HI, rnd);
    rd_reg(`FSSR_OFS_FLASH_HI, rv);
    check(rv, rnd);
    wr_reg(`FSSR_OFS_FLASH_HI, 8'h00);
    wr_reg(`FSSR_OFS_FLASH_LO, 8'h01);
    wr_reg(`FSSR_OFS_CTRL, 8'h01);
    lexp = 4'h1;
    lprev = 4'h0;
    nchg = 0;
    repeat (100) begin
      @(posedge mclk);
      if ({l4, l3, l2, l1} !== lprev) begin
        lprev = {l4, l3, l2, l1};
        nchg++;
        check({4'h0, lprev}, {4'h0, lexp});
        lexp = {lexp[2:0], lexp[3]};
      end
    end
    // One flasher rise every 8 cycles gives about 12 steps in 100 cycles.
    check({7'h0, nchg >= 10}, 8'h01);
    rd_reg(`FSSR_OFS_STATUS, rv);
    check({7'h0, rv[`FSSR_ST_LATCH_BIT]}, 8'h01);
    wr_reg(`FSSR_OFS_CTRL, 8'h00);
    repeat (4) @(posedge mclk);
    check({4'h0, l4, l3, l2, l1}, 8'h00);
    close_out();
  end
endmodule // test_four_stage_shift_register_ring
